// file: rtl/atp_params.svh
// atp_params.svh: offsets, bit positions, reset values of the timing pin block
// assumes: included by bare name from every file that needs it
`ifndef ATP_PARAMS_SVH
`define ATP_PARAMS_SVH

`define ATP_OFF_CTRL 8'h00
`define ATP_OFF_CMD 8'h04
`define ATP_OFF_SEL 8'h08
`define ATP_OFF_PFI_OE 8'h0C
`define ATP_OFF_DIO_OUT 8'h10
`define ATP_OFF_DIO_OE 8'h14
`define ATP_OFF_STROBE 8'h18
`define ATP_OFF_CHAN 8'h1C
`define ATP_OFF_POST_CNT 8'h20
`define ATP_OFF_STATUS 8'h24

`define ATP_ADDR_W 8
`define ATP_HSIZE_WORD 3'h2

`define ATP_CTRL_PRETRIG 0
`define ATP_CTRL_SCAN_EN 1
`define ATP_CTRL_ATRIG 2
`define ATP_CTRL_START_EXT 3
`define ATP_CTRL_POST_EXT 4
`define ATP_CTRL_CONV_EXT 5
`define ATP_CTRL_W 6

`define ATP_CMD_GO 0
`define ATP_CMD_ABORT 1

`define ATP_SEL_W 4
`define ATP_SEL_START_LSB 0
`define ATP_SEL_POST_LSB 4
`define ATP_SEL_CONV_LSB 8

`define ATP_STROBE_LVL 0
`define ATP_STROBE_TOG 1

`define ATP_ST_DIO_LSB 10
`define ATP_ST_STATE_LSB 18

`define ATP_CTRL_RST 6'h00
`define ATP_SEL_RST 12'h000
`define ATP_OE_RST 1'b0
`define ATP_DIO_OUT_RST 8'h00
`define ATP_STROBE_RST 1'b1
`define ATP_CHAN_RST 8'h00
`define ATP_POST_CNT_RST 16'h0010

`endif

// file: rtl/atp_pkg.sv
// atp_pkg: types of the timing pin block
// assumes: nothing
package atp_pkg;
  typedef enum logic [2:0] {
    ATP_IDLE = 3'b001,
    ATP_PRE = 3'b010,
    ATP_POST = 3'b100
  } atp_state_t;
endpackage

// file: rtl/atp_seq_if.sv
// atp_seq_if: controls and markers between the top and the sequencer
// assumes: one sequencer end, one control end
`timescale 1ns/1ps
`default_nettype none
interface atp_seq_if #(
  parameter int CNT_W = 16
);
  logic go;
  logic abort;
  logic pretrig;
  logic scan_en;
  logic post_evt;
  logic conv_evt;
  logic [CNT_W-1:0] post_count;
  logic start_mk;
  logic post_mk;
  logic conv_n;
  logic scan;
  atp_pkg::atp_state_t state;
  modport seq(input go, abort, pretrig, scan_en, post_evt, conv_evt, post_count,
    output start_mk, post_mk, conv_n, scan, state);
  modport ctl(output go, abort, pretrig, scan_en, post_evt, conv_evt, post_count,
    input start_mk, post_mk, conv_n, scan, state);
endinterface
`default_nettype wire

// file: rtl/atp_src_sel.sv
// atp_src_sel: picks one function pin or an internal strobe as event source
// assumes: pins synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module atp_src_sel #(
  parameter int N = 10,
  parameter int SW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [N-1:0] pins,
  input wire logic [SW-1:0] sel,
  input wire logic use_ext,
  input wire logic int_evt,
  output logic evt
);
  logic lvl;
  logic prev_reg;
  // any pin, shared freely between selectors
  assign lvl = (int'(sel) < N) ? pins[sel] : 1'b0;
  assign evt = use_ext ? (lvl & ~prev_reg) : int_evt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= lvl;
    end
  end
endmodule
`default_nettype wire

// file: rtl/atp_seq.sv
// atp_seq: acquisition sequencer driving start, posttrigger, convert, scan
// assumes: events are one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module atp_seq #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  atp_seq_if.seq s
);
  atp_pkg::atp_state_t state_reg;
  atp_pkg::atp_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic start_mk_reg;
  logic post_mk_reg;
  logic conv_n_reg;
  logic scan_reg;
  logic active;
  logic last_conv;

  assign active = (state_reg != atp_pkg::ATP_IDLE);
  assign last_conv = (CNT_W'(cnt_reg + 1'b1) >= s.post_count);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      atp_pkg::ATP_IDLE: begin
        if (s.go) begin
          state_next = s.pretrig ? atp_pkg::ATP_PRE : atp_pkg::ATP_POST;
        end
      end
      atp_pkg::ATP_PRE: begin
        if (s.abort) begin
          state_next = atp_pkg::ATP_IDLE;
        end else if (s.post_evt) begin
          state_next = atp_pkg::ATP_POST;
        end
      end
      atp_pkg::ATP_POST: begin
        if (s.abort || (s.conv_evt && last_conv)) begin
          state_next = atp_pkg::ATP_IDLE;
        end
      end
      default: state_next = atp_pkg::ATP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= atp_pkg::ATP_IDLE;
      cnt_reg <= '0;
      start_mk_reg <= 1'b0;
      post_mk_reg <= 1'b0;
      conv_n_reg <= 1'b1;
      scan_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      if (state_reg != atp_pkg::ATP_POST) begin
        cnt_reg <= '0;
      end else if (s.conv_evt) begin
        cnt_reg <= CNT_W'(cnt_reg + 1'b1);
      end
      // rises on entering pre or post phase
      start_mk_reg <= (state_next != atp_pkg::ATP_IDLE);
      // only a pre to post step raises it
      if (state_next == atp_pkg::ATP_IDLE) begin
        post_mk_reg <= 1'b0;
      end else if (state_reg == atp_pkg::ATP_PRE && state_next == atp_pkg::ATP_POST) begin
        post_mk_reg <= 1'b1;
      end
      conv_n_reg <= ~(s.conv_evt & active);
      // one pulse right after each conversion
      scan_reg <= s.scan_en & ~conv_n_reg;
    end
  end

  assign s.state = state_reg;
  assign s.start_mk = start_mk_reg;
  assign s.post_mk = post_mk_reg;
  assign s.conv_n = conv_n_reg;
  assign s.scan = scan_reg;

  a_scan_per_conv: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    !conv_n_reg |=> scan_reg == $past(s.scan_en))
    else $error("scan pulse missing after conversion");
  a_scan_cause: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(scan_reg) |-> $past(!conv_n_reg))
    else $error("scan pulse without conversion");
  a_post_only_start: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    state_reg == atp_pkg::ATP_IDLE && s.go && !s.pretrig |=> start_mk_reg && state_reg == atp_pkg::ATP_POST)
    else $error("start marker not raised");
  a_pre_start: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    state_reg == atp_pkg::ATP_IDLE && s.go && s.pretrig |=> start_mk_reg && !post_mk_reg)
    else $error("pretrigger start wrong");
  a_post_marker: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    state_reg == atp_pkg::ATP_PRE && s.post_evt && !s.abort |=> $rose(post_mk_reg))
    else $error("posttrigger marker not raised");
  a_post_quiet: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(post_mk_reg) |-> $past(state_reg) == atp_pkg::ATP_PRE)
    else $error("posttrigger marker outside pretrigger");
  a_conv_edge: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    s.conv_evt && active |=> !conv_n_reg)
    else $error("conversion marker missing");
  c_pretrig_run: cover property (@(posedge clk) disable iff (!rst_n) $rose(post_mk_reg));
  c_scan: cover property (@(posedge clk) disable iff (!rst_n) $rose(scan_reg));
endmodule
`default_nettype wire

// file: rtl/atp_top.sv
// atp_top: connector timing pins, markers, strobe and general io lines
// assumes: AHB-Lite single word transfers, pins synchronous to hclk
// Functional notes
// - one scan pulse per conversion
// - scan pulse rise marks input release
// - software sets or toggles strobe level
// - pin 0 feeds functions or analog trigger
// - posttrigger run raises start marker
// - pretrigger run raises start marker
// - pretrigger run raises posttrigger marker later
// - posttrigger marker idle in posttrigger-only runs
// - conversion marker falls per conversion
// - io lines 6, 7 give counter direction
// - channel pairs differential or two single-ended
// - any timing signal selects any pin; here only input events do, markers fixed on pins 0..2
// - each function pin has driver enable
// - io lines released after reset
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "atp_params.svh"
module atp_top #(
  parameter int PFI_N = 10,
  parameter int DIO_N = 8,
  parameter int PAIR_N = 8,
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [PFI_N-1:0] programmable_function_pin_in,
  output logic [PFI_N-1:0] programmable_function_pin_out,
  output logic [PFI_N-1:0] programmable_function_pin_oe,
  input wire logic [PFI_N-4:0] timing_out_misc,
  input wire logic int_post_trigger,
  input wire logic int_convert,
  input wire logic [DIO_N-1:0] general_io_lines_in,
  output logic [DIO_N-1:0] general_io_lines_out,
  output logic [DIO_N-1:0] general_io_lines_oe,
  output logic [1:0] counter_up_down,
  output logic analog_trigger_in,
  output logic software_strobe_out_n,
  output logic scan_conversion_pulse,
  output logic conversion_marker_n,
  output logic acquisition_start_marker,
  output logic posttrigger_start_marker,
  output logic [PAIR_N-1:0] analog_channel_diff,
  output logic [2*PAIR_N-1:0] analog_channel_single_ended,
  output logic acquisition_busy
);
  // bus pipeline
  logic dp_wr_reg;
  logic dp_rd_reg;
  logic rd_done_reg;
  logic [`ATP_ADDR_W-1:0] dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_mux;
  logic accept;
  logic wr_en;

  // registers
  logic [`ATP_CTRL_W-1:0] ctrl_reg;
  logic [3*`ATP_SEL_W-1:0] sel_reg;
  logic [PFI_N-1:0] pfi_oe_reg;
  logic [DIO_N-1:0] dio_out_reg;
  logic [DIO_N-1:0] dio_oe_reg;
  logic strobe_reg;
  logic strobe_next;
  logic [PAIR_N-1:0] chan_reg;
  logic [CNT_W-1:0] post_cnt_reg;

  // write strobes
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_sel;
  logic wr_pfi_oe;
  logic wr_dio_out;
  logic wr_dio_oe;
  logic wr_strobe;
  logic wr_chan;
  logic wr_post_cnt;

  logic sw_go;
  logic sw_abort;

  atp_seq_if #(.CNT_W(CNT_W)) sq();

  // address phase taken only for word transfers
  assign accept = hsel & hready & htrans[1] & (hsize == `ATP_HSIZE_WORD);
  assign hreadyout = ce & (~dp_rd_reg | rd_done_reg);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign wr_en = ce & dp_wr_reg;

  assign wr_ctrl = wr_en & (dp_addr_reg == `ATP_OFF_CTRL);
  assign wr_cmd = wr_en & (dp_addr_reg == `ATP_OFF_CMD);
  assign wr_sel = wr_en & (dp_addr_reg == `ATP_OFF_SEL);
  assign wr_pfi_oe = wr_en & (dp_addr_reg == `ATP_OFF_PFI_OE);
  assign wr_dio_out = wr_en & (dp_addr_reg == `ATP_OFF_DIO_OUT);
  assign wr_dio_oe = wr_en & (dp_addr_reg == `ATP_OFF_DIO_OE);
  assign wr_strobe = wr_en & (dp_addr_reg == `ATP_OFF_STROBE);
  assign wr_chan = wr_en & (dp_addr_reg == `ATP_OFF_CHAN);
  assign wr_post_cnt = wr_en & (dp_addr_reg == `ATP_OFF_POST_CNT);

  assign sw_go = wr_cmd & hwdata[`ATP_CMD_GO];
  assign sw_abort = wr_cmd & hwdata[`ATP_CMD_ABORT];

  // toggle bit wins over the level bit
  assign strobe_next = hwdata[`ATP_STROBE_TOG] ? ~strobe_reg : hwdata[`ATP_STROBE_LVL];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dp_addr_reg == `ATP_OFF_CTRL) begin
      rd_mux[`ATP_CTRL_W-1:0] = ctrl_reg;
    end else if (dp_addr_reg == `ATP_OFF_SEL) begin
      rd_mux[3*`ATP_SEL_W-1:0] = sel_reg;
    end else if (dp_addr_reg == `ATP_OFF_PFI_OE) begin
      rd_mux[PFI_N-1:0] = pfi_oe_reg;
    end else if (dp_addr_reg == `ATP_OFF_DIO_OUT) begin
      rd_mux[DIO_N-1:0] = dio_out_reg;
    end else if (dp_addr_reg == `ATP_OFF_DIO_OE) begin
      rd_mux[DIO_N-1:0] = dio_oe_reg;
    end else if (dp_addr_reg == `ATP_OFF_STROBE) begin
      rd_mux[`ATP_STROBE_LVL] = strobe_reg;
    end else if (dp_addr_reg == `ATP_OFF_CHAN) begin
      rd_mux[PAIR_N-1:0] = chan_reg;
    end else if (dp_addr_reg == `ATP_OFF_POST_CNT) begin
      rd_mux[CNT_W-1:0] = post_cnt_reg;
    end else if (dp_addr_reg == `ATP_OFF_STATUS) begin
      rd_mux[PFI_N-1:0] = programmable_function_pin_in;
      rd_mux[`ATP_ST_DIO_LSB +: DIO_N] = general_io_lines_in;
      rd_mux[`ATP_ST_STATE_LSB +: 3] = sq.state;
    end
  end

  // reads take one wait state so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      rd_done_reg <= 1'b0;
      dp_addr_reg <= '0;
      hrdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      if (hreadyout) begin
        dp_wr_reg <= accept & hwrite;
        dp_rd_reg <= accept & ~hwrite;
        dp_addr_reg <= haddr[`ATP_ADDR_W-1:0];
        rd_done_reg <= 1'b0;
      end else if (dp_rd_reg) begin
        hrdata_reg <= rd_mux;
        rd_done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `ATP_CTRL_RST;
      sel_reg <= `ATP_SEL_RST;
      pfi_oe_reg <= {PFI_N{`ATP_OE_RST}};
      dio_oe_reg <= {DIO_N{`ATP_OE_RST}};
      dio_out_reg <= `ATP_DIO_OUT_RST;
      strobe_reg <= `ATP_STROBE_RST;
      chan_reg <= `ATP_CHAN_RST;
      post_cnt_reg <= `ATP_POST_CNT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[`ATP_CTRL_W-1:0];
      end
      if (wr_sel) begin
        sel_reg <= hwdata[3*`ATP_SEL_W-1:0];
      end
      if (wr_pfi_oe) begin
        pfi_oe_reg <= hwdata[PFI_N-1:0];
      end
      if (wr_dio_oe) begin
        dio_oe_reg <= hwdata[DIO_N-1:0];
      end
      if (wr_dio_out) begin
        dio_out_reg <= hwdata[DIO_N-1:0];
      end
      if (wr_strobe) begin
        strobe_reg <= strobe_next;
      end
      if (wr_chan) begin
        chan_reg <= hwdata[PAIR_N-1:0];
      end
      if (wr_post_cnt) begin
        post_cnt_reg <= hwdata[CNT_W-1:0];
      end
    end
  end

  // event sources for the sequencer
  atp_src_sel #(.N(PFI_N), .SW(`ATP_SEL_W)) u_start_src (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .pins(programmable_function_pin_in),
    .sel(sel_reg[`ATP_SEL_START_LSB +: `ATP_SEL_W]),
    .use_ext(ctrl_reg[`ATP_CTRL_START_EXT]),
    .int_evt(sw_go),
    .evt(sq.go)
  );
  atp_src_sel #(.N(PFI_N), .SW(`ATP_SEL_W)) u_post_src (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .pins(programmable_function_pin_in),
    .sel(sel_reg[`ATP_SEL_POST_LSB +: `ATP_SEL_W]),
    .use_ext(ctrl_reg[`ATP_CTRL_POST_EXT]),
    .int_evt(int_post_trigger),
    .evt(sq.post_evt)
  );
  atp_src_sel #(.N(PFI_N), .SW(`ATP_SEL_W)) u_conv_src (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .pins(programmable_function_pin_in),
    .sel(sel_reg[`ATP_SEL_CONV_LSB +: `ATP_SEL_W]),
    .use_ext(ctrl_reg[`ATP_CTRL_CONV_EXT]),
    .int_evt(int_convert),
    .evt(sq.conv_evt)
  );

  assign sq.abort = sw_abort;
  assign sq.pretrig = ctrl_reg[`ATP_CTRL_PRETRIG];
  assign sq.scan_en = ctrl_reg[`ATP_CTRL_SCAN_EN];
  assign sq.post_count = post_cnt_reg;

  atp_seq #(.CNT_W(CNT_W)) u_seq (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .s(sq.seq)
  );

  // pins 0..2 carry the markers, the rest their own timing signals
  assign programmable_function_pin_out = {timing_out_misc, sq.conv_n, sq.post_mk, sq.start_mk};
  assign programmable_function_pin_oe = pfi_oe_reg;
  assign acquisition_start_marker = sq.start_mk;
  assign posttrigger_start_marker = sq.post_mk;
  assign conversion_marker_n = sq.conv_n;
  assign scan_conversion_pulse = sq.scan;
  assign acquisition_busy = (sq.state != atp_pkg::ATP_IDLE);

  // pin 0 level also drives the analog trigger path
  assign analog_trigger_in = ctrl_reg[`ATP_CTRL_ATRIG] & programmable_function_pin_in[0];
  assign software_strobe_out_n = strobe_reg;
  assign general_io_lines_out = dio_out_reg;
  assign general_io_lines_oe = dio_oe_reg;
  // direction inputs only, io lines unaffected
  assign counter_up_down = general_io_lines_in[7:6];

  // pair i with i+PAIR_N
  generate
    for (genvar i = 0; i < PAIR_N; i++) begin : g_pair
      assign analog_channel_diff[i] = chan_reg[i];
      assign analog_channel_single_ended[i] = ~chan_reg[i];
      assign analog_channel_single_ended[i+PAIR_N] = ~chan_reg[i];
    end
  endgenerate

  a_strobe_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_strobe && hwdata[`ATP_STROBE_TOG] |=> software_strobe_out_n == !$past(software_strobe_out_n))
    else $error("strobe did not toggle");
  a_pin_drv_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pfi_oe |=> programmable_function_pin_oe == $past(hwdata[PFI_N-1:0]))
    else $error("pin driver enable not written");
  a_drv_off_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> programmable_function_pin_oe == '0)
    else $error("pin drivers on after reset");
  a_io_hiz_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> general_io_lines_oe == '0)
    else $error("io lines driven after reset");
  a_pair_map: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_chan |=> analog_channel_single_ended[PAIR_N] == !$past(hwdata[0]))
    else $error("channel pair map wrong");
  c_strobe: cover property (@(posedge hclk) disable iff (!hresetn) wr_strobe);
  c_read_status: cover property (@(posedge hclk) disable iff (!hresetn)
    dp_rd_reg && dp_addr_reg == `ATP_OFF_STATUS && hreadyout);
endmodule
`default_nettype wire

// file: bench/atp_ext_model.sv
// atp_ext_model: circuitry wired to the connector side of the timing pins
// assumes: bench sets what it drives just after hclk rises
`timescale 1ns/1ps
`default_nettype none
module atp_ext_model (
  input wire logic hclk,
  input wire logic [9:0] pfi_out,
  input wire logic [9:0] pfi_oe,
  input wire logic [9:0] pfi_val,
  input wire logic [9:0] pfi_en,
  input wire logic [7:0] dio_out,
  input wire logic [7:0] dio_oe,
  input wire logic [7:0] dio_val,
  input wire logic [7:0] dio_en,
  output logic [9:0] pfi_wire,
  output logic [7:0] dio_wire
);
  logic [9:0] float_q = 10'h000;
  // no pull on function pins: an undriven pin wanders
  always @(posedge hclk) float_q <= ~float_q;
  assign pfi_wire = (pfi_oe & pfi_out) | (~pfi_oe & pfi_en & pfi_val) | (~pfi_oe & ~pfi_en & float_q);
  // io lines carry pull-ups
  assign dio_wire = (dio_oe & dio_out) | (~dio_oe & dio_en & dio_val) | (~dio_oe & ~dio_en);
endmodule
`default_nettype wire

// file: bench/acq_timing_pin_interface_bench.sv
// acq_timing_pin_interface_bench: self-checking bench of atp_top
// assumes: one AHB-Lite master here, connector modelled by atp_ext_model
`timescale 1ns/1ps
`default_nettype none
`include "atp_params.svh"
module acq_timing_pin_interface_bench;
  logic hclk, hresetn, ce, hsel, hwrite, hresp, ipt, icv, hrdy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, updn;
  logic [2:0] hsize;
  logic [6:0] misc;
  logic [9:0] pval, pen, pin_in, pin_out, pin_oe;
  logic [7:0] dval, den, io_in, io_out, io_oe, diff;
  logic [15:0] se;
  logic atrig, strb_n, scan, conv_n, start_mk, post_mk, busy;
  int n_mismatch = 0;
  int checks = 0;
  int scans = 0;

  atp_top u_atp_top (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hrdy), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .programmable_function_pin_in(pin_in),
    .programmable_function_pin_out(pin_out), .programmable_function_pin_oe(pin_oe),
    .timing_out_misc(misc), .int_post_trigger(ipt), .int_convert(icv),
    .general_io_lines_in(io_in), .general_io_lines_out(io_out), .general_io_lines_oe(io_oe),
    .counter_up_down(updn), .analog_trigger_in(atrig), .software_strobe_out_n(strb_n),
    .scan_conversion_pulse(scan), .conversion_marker_n(conv_n),
    .acquisition_start_marker(start_mk), .posttrigger_start_marker(post_mk),
    .analog_channel_diff(diff), .analog_channel_single_ended(se), .acquisition_busy(busy));

  atp_ext_model u_atp_ext_model (.hclk(hclk), .pfi_out(pin_out), .pfi_oe(pin_oe), .pfi_val(pval),
    .pfi_en(pen), .dio_out(io_out), .dio_oe(io_oe), .dio_val(dval), .dio_en(den),
    .pfi_wire(pin_in), .dio_wire(io_in));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk) if (hresetn && scan === 1'b1) scans++;

  task automatic complete_run;
    $display("counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic hang(input string m);
    n_mismatch++;
    $display("Error %0t: no answer, %s", $time, m);
    complete_run;
  endtask

  task automatic chk_bit(input logic a, input logic e, input string m);
    checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("Error %0t: %s got %b exp %b", $time, m, a, e);
    end
  endtask

  task automatic chk_vec(input logic [31:0] a, input logic [31:0] e, input string m);
    checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("Error %0t: %s got %h exp %h", $time, m, a, e);
    end
  endtask

  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 50) hang("bus");
      @(posedge hclk);
    end
    d = hrdata;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= `ATP_HSIZE_WORD;
    wait_rdy(d);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000, rd);
    chk_vec(rd, e, "register read");
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return start_mk;
      1: return post_mk;
      2: return conv_n;
      default: return scan;
    endcase
  endfunction

  task automatic wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (sig(k) !== v) begin
      n++;
      if (n > 40) hang("marker");
      @(posedge hclk);
      #1;
    end
    checks++;
  endtask

  task automatic pulse(input logic post);
    @(posedge hclk);
    if (post) ipt <= 1'b1;
    else icv <= 1'b1;
    @(posedge hclk);
    ipt <= 1'b0;
    icv <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    chk_vec(32'(pin_oe), 32'h0, "pin drivers in reset");
    chk_vec(32'(io_oe), 32'h0, "io drivers in reset");
    chk_bit(strb_n, 1'b1, "strobe in reset");
    chk_bit(conv_n, 1'b1, "convert marker in reset");
    chk_bit(start_mk | post_mk, 1'b0, "markers in reset");
    chk_bit(hresp | busy, 1'b0, "response and busy in reset");
    @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`ATP_OFF_POST_CNT, 32'h00000010);
    rdchk(8'h40, 32'h00000000);
    rdchk(`ATP_OFF_STATUS, 32'h0007FC00);
    $display("reset test done");
  endtask

  task automatic t_strobe;
    wr(`ATP_OFF_STROBE, 32'h0);
    chk_bit(strb_n, 1'b0, "strobe load");
    wr(`ATP_OFF_STROBE, 32'h2);
    chk_bit(strb_n, 1'b1, "strobe toggle");
    wr(`ATP_OFF_STROBE, 32'h2);
    chk_bit(strb_n, 1'b0, "strobe toggle back");
    rdchk(`ATP_OFF_STROBE, 32'h0);
    $display("strobe test done");
  endtask

  task automatic t_post_only;
    int s0;
    wr(`ATP_OFF_CTRL, 32'h2);
    wr(`ATP_OFF_POST_CNT, 32'h2);
    s0 = scans;
    wr(`ATP_OFF_CMD, 32'h1);
    wait_for(0, 1'b1);
    pulse(1'b0);
    wait_for(2, 1'b0);
    wait_for(3, 1'b1);
    chk_bit(conv_n, 1'b1, "convert marker after scan");
    pulse(1'b0);
    chk_bit(post_mk, 1'b0, "posttrigger marker unused");
    wait_for(0, 1'b0);
    repeat (3) @(posedge hclk);
    chk_vec(32'(scans - s0), 32'h2, "scan pulses");
    $display("posttrigger test done");
  endtask

  task automatic t_pretrig;
    int s0;
    wr(`ATP_OFF_CTRL, 32'h1);
    wr(`ATP_OFF_POST_CNT, 32'h1);
    s0 = scans;
    wr(`ATP_OFF_CMD, 32'h1);
    wait_for(0, 1'b1);
    chk_bit(busy, 1'b1, "busy in pretrigger");
    chk_bit(post_mk, 1'b0, "posttrigger marker early");
    pulse(1'b0);
    wait_for(2, 1'b0);
    pulse(1'b1);
    wait_for(1, 1'b1);
    chk_bit(start_mk, 1'b1, "start marker held");
    pulse(1'b0);
    wait_for(1, 1'b0);
    chk_bit(start_mk, 1'b0, "start marker ends");
    chk_vec(32'(scans - s0), 32'h0, "scan pulses disabled");
    $display("pretrigger test done");
  endtask

  task automatic t_ext_src;
    wr(`ATP_OFF_CTRL, 32'h28);
    wr(`ATP_OFF_SEL, 32'h505);
    @(posedge hclk);
    pval[5] <= 1'b1;
    wait_for(0, 1'b1);
    @(posedge hclk);
    pval[5] <= 1'b0;
    @(posedge hclk);
    pval[5] <= 1'b1;
    wait_for(2, 1'b0);
    wait_for(0, 1'b0);
    @(posedge hclk);
    pval[5] <= 1'b0;
    $display("shared source test done");
  endtask

  task automatic t_atrig_dio;
    wr(`ATP_OFF_CTRL, 32'h4);
    @(posedge hclk);
    pval[0] <= 1'b1;
    #1;
    chk_bit(atrig, 1'b1, "analog trigger source");
    wr(`ATP_OFF_CTRL, 32'h0);
    chk_bit(atrig, 1'b0, "analog trigger off");
    wr(`ATP_OFF_DIO_OE, 32'hFF);
    wr(`ATP_OFF_DIO_OUT, 32'hA5);
    chk_vec(32'({io_oe, io_out}), 32'hFFA5, "io drive");
    chk_vec(32'(updn), 32'h2, "counter direction driven");
    wr(`ATP_OFF_DIO_OE, 32'h0);
    den <= 8'hFF;
    dval <= 8'h40;
    #1;
    chk_vec(32'(updn), 32'h1, "counter direction external");
    $display("trigger and io test done");
  endtask

  task automatic t_oe_chan;
    wr(`ATP_OFF_PFI_OE, 32'h3FF);
    chk_vec(32'(pin_oe), 32'h3FF, "pin drivers");
    chk_vec(32'(pin_out), 32'h2AC, "pin outputs");
    rdchk(`ATP_OFF_PFI_OE, 32'h3FF);
    wr(`ATP_OFF_PFI_OE, 32'h0);
    wr(`ATP_OFF_CHAN, 32'h81);
    chk_vec(32'({se, diff}), 32'h7E7E81, "channel pairs");
    $display("driver and channel test done");
  endtask

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    misc = 7'h55;
    ipt = 1'b0;
    icv = 1'b0;
    pval = 10'h000;
    pen = 10'h3FF;
    dval = 8'h00;
    den = 8'h00;
    repeat (3) @(posedge hclk);
    #1;
    t_reset;
    t_strobe;
    t_post_only;
    t_pretrig;
    t_ext_src;
    t_atrig_dio;
    t_oe_chan;
    complete_run;
  end
endmodule
`default_nettype wire
